// ---- dtm_regs.svh ----
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH
// Register byte offsets.
`define DTM_A_CTRL    8'h00
`define DTM_A_LAT     8'h04
`define DTM_A_MWIN    8'h08
`define DTM_A_KWIN    8'h0C
`define DTM_A_STAT    8'h10
`define DTM_A_TIME    8'h14
// Reset values.
`define DTM_CTRL_RST  2'h1
`define DTM_MWIN_RST  12'h0050
`define DTM_KWIN_RST  12'h0050
// Timing figures.
`define DTM_CLK_PS    10000
`define DTM_LAT_NS    2500
`define DTM_LAT_CYC   ((`DTM_LAT_NS * 1000) / `DTM_CLK_PS)
`define DTM_FBINS     32
`define DTM_FBIN_PS   (`DTM_CLK_PS / `DTM_FBINS)
`define DTM_CHG_NS    150
`define DTM_CHG_MAX   ((`DTM_CHG_NS * 1000) / `DTM_FBIN_PS)
`define DTM_TRL_NS    1500
`define DTM_TRL_BINPS 6250
`define DTM_TRL_DIV   (`DTM_TRL_BINPS / `DTM_FBIN_PS)
`define DTM_TRL_MAX   ((`DTM_TRL_NS * 1000) / `DTM_TRL_BINPS)
// Revolution length and command timing.
`define DTM_REV       13'h0DEC
`define DTM_REV_LAST  12'h0DEB
`define DTM_CMD_DLY   12'h0002
// Command codes carried after the start bit.
`define DTM_CMD_TRIG  2'h0
`define DTM_CMD_BCR   2'h1
`define DTM_CMD_ECR   2'h2
`define DTM_CMD_GRST  2'h3
// Readout word type fields.
`define DTM_W_HEAD    2'h0
`define DTM_W_MASK    2'h1
`endif

// ---- dtm_pkg.sv ----
package dtm_pkg;
   // Command decoder states.
   typedef enum logic [1:0] {DTM_C_IDLE, DTM_C_B1, DTM_C_B2} dtm_cmd_st_type;
   // Trigger matcher states.
   typedef enum logic [1:0] {DTM_M_IDLE, DTM_M_HEAD, DTM_M_SCAN, DTM_M_MASK} dtm_mst_type;
endpackage

// ---- dtm_core.sv ----
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "dtm_regs.svh"
module dtm_core #(
   parameter int N_CH   = 24,
   parameter int DEPTH  = 256,
   parameter int EVID_W = 12
) (
   // Clock and reset.
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave.
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   // Discriminated hits and fine phase at each edge.
   input  wire logic [N_CH-1:0]    hit_i,
   input  wire logic [N_CH*5-1:0]  hit_fine_i,
   // Encoded control line.
   input  wire logic               ttc_cmd_i,
   // Readout stream.
   output logic      [31:0]        rd_data_o,
   output logic                    rd_valid_o,
   input  wire logic               rd_ready_i
);
   localparam int AW = $clog2(DEPTH);

   // Refuse sizes that the channel field, the pointers or the event field cannot hold.
   if (N_CH < 1 || N_CH > 30) begin : g_bad_nch
      $error("N_CH must be 1..30");
   end
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("DEPTH must be a power of two");
   end
   if (EVID_W != 12 && EVID_W != 8) begin : g_bad_evid
      $error("EVID_W must be 8 or 12");
   end

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // Distance a-b around the revolution, in 0..3563 when both inputs are below 3564.
   function automatic logic [11:0] rev_diff(input logic [11:0] a, input logic [11:0] b);
      logic [12:0] s;
      s = (a >= b) ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + `DTM_REV - {1'b0, b});
      return s[11:0];
   endfunction

   // Index of the lowest set bit, zero if none.
   function automatic logic [4:0] first_set(input logic [N_CH-1:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = N_CH - 1; i >= 0; i--) begin
         if (v[i]) r = 5'(i);
      end
      return r;
   endfunction

   // Pulse width in output bins, saturated per mode.
   function automatic logic [8:0] width_calc(input logic [7:0] cyc, input logic [4:0] ft,
                                              input logic [4:0] fl, input logic trl);
      logic [13:0] t;
      logic [13:0] q;
      t = {1'b0, cyc, 5'h00} + 14'h0020 + {9'h000, ft} - {9'h000, fl};
      q = trl ? 14'(t / `DTM_TRL_DIV) : t;
      if (trl) begin
         return (q > 14'(`DTM_TRL_MAX)) ? 9'(`DTM_TRL_MAX) : q[8:0];
      end
      return (q > 14'(`DTM_CHG_MAX)) ? 9'(`DTM_CHG_MAX) : q[8:0];
   endfunction

   // Byte-lane merge for Wishbone writes.
   function automatic logic [31:0] wb_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------

   logic [1:0]        ctrl_q;     // Bit 0 enable, bit 1 trailing-edge mode.
   logic [11:0]       lat_q;      // Trigger latency in cycles.
   logic [11:0]       mwin_q;     // Matching window length.
   logic [11:0]       kwin_q;     // Mask window length.
   logic [1:0]        ovf_q;      // Sticky: bit 0 hit lost, bit 1 trigger lost.
   logic              wb_req;     // New Wishbone request this cycle.
   logic [31:0]       wd;         // Merged write data.
   logic              hit_lost;   // A hit overran its channel slot.
   logic              trg_lost;   // A trigger found the queue full or capture disabled.
   logic [11:0]       coarse_q;   // Coarse time counter.
   logic [EVID_W-1:0] evid_q;     // Local event number.
   logic [4:0]        tq_cnt;     // Trigger queue fill level.

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wd     = wb_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

   // Acknowledge every request one cycle after it is presented.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Register writes; status flags are set by hardware, cleared by a write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `DTM_CTRL_RST;
         lat_q  <= 12'(`DTM_LAT_CYC);
         mwin_q <= `DTM_MWIN_RST;
         kwin_q <= `DTM_KWIN_RST;
         ovf_q  <= 2'h0;
      end else begin
         if (wb_req && wb_we_i) begin
            case (wb_adr_i)
               `DTM_A_CTRL: ctrl_q <= wd[1:0];
               `DTM_A_LAT:  lat_q  <= wd[11:0];
               `DTM_A_MWIN: mwin_q <= wd[11:0];
               `DTM_A_KWIN: kwin_q <= wd[11:0];
               `DTM_A_STAT: ovf_q  <= ovf_q & ~wd[1:0];
               default: begin
               end
            endcase
         end
         // A new event in the clear cycle survives.
         if (hit_lost) ovf_q[0] <= 1'b1;
         if (trg_lost) ovf_q[1] <= 1'b1;
      end
   end

   // Registered read data; unmapped offsets read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req) begin
         case (wb_adr_i)
            `DTM_A_CTRL: wb_dat_o <= {30'h0, ctrl_q};
            `DTM_A_LAT:  wb_dat_o <= {20'h0, lat_q};
            `DTM_A_MWIN: wb_dat_o <= {20'h0, mwin_q};
            `DTM_A_KWIN: wb_dat_o <= {20'h0, kwin_q};
            `DTM_A_STAT: wb_dat_o <= {25'h0, tq_cnt, ovf_q};
            `DTM_A_TIME: wb_dat_o <= {4'h0, 12'(evid_q), 4'h0, coarse_q};
            default:     wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command decoder
   // ----------------------------------------------------------------

   dtm_pkg::dtm_cmd_st_type cst_q;
   logic        code_q;   // First code bit.
   logic [11:0] ct_q;     // Coarse time of the start bit.
   logic        trig;
   logic        bcr;
   logic        ecr;
   logic        grst;
   logic [1:0]  code;

   assign code = {code_q, ttc_cmd_i};
   assign trig = (cst_q == dtm_pkg::DTM_C_B2) && (code == `DTM_CMD_TRIG);
   assign bcr  = (cst_q == dtm_pkg::DTM_C_B2) && (code == `DTM_CMD_BCR);
   assign ecr  = (cst_q == dtm_pkg::DTM_C_B2) && (code == `DTM_CMD_ECR);
   assign grst = (cst_q == dtm_pkg::DTM_C_B2) && (code == `DTM_CMD_GRST);

   // A start bit then two code bits; spacing keeps commands apart.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cst_q  <= dtm_pkg::DTM_C_IDLE;
         code_q <= 1'b0;
         ct_q   <= 12'h000;
      end else begin
         case (cst_q)
            dtm_pkg::DTM_C_IDLE: begin
               if (ttc_cmd_i) begin
                  cst_q <= dtm_pkg::DTM_C_B1;
                  ct_q  <= coarse_q;
               end
            end
            dtm_pkg::DTM_C_B1: begin
               code_q <= ttc_cmd_i;
               cst_q  <= dtm_pkg::DTM_C_B2;
            end
            default: cst_q <= dtm_pkg::DTM_C_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Coarse and event counters
   // ----------------------------------------------------------------

   // Wraps after one revolution; bunch reset realigns to the start bit.
   always_ff @(posedge clk_i) begin
      if (rst_i || grst) begin
         coarse_q <= 12'h000;
      end else if (bcr) begin
         coarse_q <= `DTM_CMD_DLY;
      end else if (coarse_q == `DTM_REV_LAST) begin
         coarse_q <= 12'h000;
      end else begin
         coarse_q <= coarse_q + 12'h001;
      end
   end

   // Counts every trigger; an event reset or a global reset clears it.
   always_ff @(posedge clk_i) begin
      if (rst_i || grst || ecr) begin
         evid_q <= '0;
      end else if (trig) begin
         evid_q <= evid_q + EVID_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // Channel capture
   // ----------------------------------------------------------------

   logic [N_CH-1:0] lvl_q;            // Previous hit level.
   logic [N_CH-1:0] busy_q;           // Pulse in progress.
   logic [N_CH-1:0] pend_q;           // Finished hit awaiting buffer.
   logic [N_CH-1:0] gnt;              // One-hot buffer grant.
   logic [N_CH-1:0] lost_v;           // Hit overran a full slot.
   logic [11:0]     lead_c_q [N_CH];  // Leading edge coarse time.
   logic [4:0]      lead_f_q [N_CH];  // Leading edge fine time.
   logic [7:0]      wcnt_q   [N_CH];  // Cycles since leading edge.
   logic [8:0]      wid_q    [N_CH];  // Finished pulse width.
   logic [4:0]      win;              // Granted channel.

   assign win      = first_set(pend_q);
   assign gnt      = (|pend_q) ? (N_CH'(1) << win) : '0;
   assign hit_lost = |lost_v;

   for (genvar gi = 0; gi < N_CH; gi++) begin : g_ch
      logic fall;
      assign fall       = busy_q[gi] && !hit_i[gi];
      assign lost_v[gi] = fall && pend_q[gi] && !gnt[gi];

      // Each channel owns a one-hit slot so bursts on many lines all land.
      always_ff @(posedge clk_i) begin
         if (rst_i || grst) begin
            lvl_q[gi]    <= 1'b0;
            busy_q[gi]   <= 1'b0;
            pend_q[gi]   <= 1'b0;
            lead_c_q[gi] <= 12'h000;
            lead_f_q[gi] <= 5'h00;
            wcnt_q[gi]   <= 8'h00;
            wid_q[gi]    <= 9'h000;
         end else begin
            lvl_q[gi] <= hit_i[gi];
            if (gnt[gi]) pend_q[gi] <= 1'b0;
            if (hit_i[gi] && !lvl_q[gi] && ctrl_q[0]) begin
               busy_q[gi]   <= 1'b1;
               lead_c_q[gi] <= coarse_q;
               lead_f_q[gi] <= hit_fine_i[gi*5 +: 5];
               wcnt_q[gi]   <= 8'h00;
            end else if (fall) begin
               busy_q[gi] <= 1'b0;
               if (!lost_v[gi]) begin
                  pend_q[gi] <= 1'b1;
                  wid_q[gi]  <= width_calc(wcnt_q[gi], hit_fine_i[gi*5 +: 5], lead_f_q[gi], ctrl_q[1]);
               end
            end else if (busy_q[gi] && wcnt_q[gi] != 8'hFF) begin
               wcnt_q[gi] <= wcnt_q[gi] + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // First-level buffer
   // ----------------------------------------------------------------

   logic [30:0]      mem [DEPTH];  // {chan, coarse, fine, width}.
   logic [DEPTH-1:0] vld_q;        // Entry holds a hit.
   logic [AW-1:0]    wr_ptr_q;     // Next slot, oldest overwritten.
   logic             wr_en;

   assign wr_en = |pend_q;

   // One hit per cycle, lowest pending channel first.
   always_ff @(posedge clk_i) begin
      if (rst_i || grst) begin
         vld_q    <= '0;
         wr_ptr_q <= '0;
      end else if (wr_en) begin
         vld_q[wr_ptr_q] <= 1'b1;
         wr_ptr_q        <= wr_ptr_q + AW'(1);
      end
   end

   // Storage itself needs no reset.
   always_ff @(posedge clk_i) begin
      if (wr_en) begin
         mem[wr_ptr_q] <= {win, lead_c_q[win], lead_f_q[win], wid_q[win]};
      end
   end

   // ----------------------------------------------------------------
   // Trigger queue
   // ----------------------------------------------------------------

   logic [11:0]       tq_t [16];  // Trigger coarse time.
   logic [EVID_W-1:0] tq_e [16];  // Trigger event number.
   logic [4:0]        tq_wp_q;
   logic [4:0]        tq_rp_q;
   logic              tq_pop;

   assign tq_cnt   = tq_wp_q - tq_rp_q;
   assign trg_lost = trig && (tq_cnt[4] || !ctrl_q[0]);

   // Holds up to sixteen pending triggers for the matcher.
   always_ff @(posedge clk_i) begin
      if (rst_i || grst) begin
         tq_wp_q <= 5'h00;
         tq_rp_q <= 5'h00;
      end else begin
         if (trig && !trg_lost) begin
            tq_t[tq_wp_q[3:0]] <= ct_q;
            tq_e[tq_wp_q[3:0]] <= evid_q;
            tq_wp_q            <= tq_wp_q + 5'h01;
         end
         if (tq_pop) tq_rp_q <= tq_rp_q + 5'h01;
      end
   end

   // ----------------------------------------------------------------
   // Trigger matcher
   // ----------------------------------------------------------------

   dtm_pkg::dtm_mst_type mst_q;
   logic [AW-1:0]   idx_q;    // Entry under inspection.
   logic [11:0]     ref_q;    // Window start: trigger time minus latency.
   logic [N_CH-1:0] mask_q;   // Masked-hit flags of this event.
   logic [30:0]     ent;
   logic            is_match;
   logic            is_mask;
   logic            go;
   logic [4:0]      ent_ch;

   assign ent      = mem[idx_q];
   assign ent_ch   = ent[30:26];
   assign is_match = vld_q[idx_q] && (rev_diff(ent[25:14], ref_q) < mwin_q);
   assign is_mask  = vld_q[idx_q] && !is_match && (rev_diff(ref_q, ent[25:14]) != 12'h000)
                     && (rev_diff(ref_q, ent[25:14]) <= kwin_q);
   assign go       = !rd_valid_o || rd_ready_i;
   assign tq_pop   = (mst_q == dtm_pkg::DTM_M_MASK) && go;

   // Header, a scan of the whole buffer, then the mask word.
   always_ff @(posedge clk_i) begin
      if (rst_i || grst) begin
         mst_q      <= dtm_pkg::DTM_M_IDLE;
         idx_q      <= '0;
         ref_q      <= 12'h000;
         mask_q     <= '0;
         rd_valid_o <= 1'b0;
         rd_data_o  <= 32'h0000_0000;
      end else begin
         if (rd_ready_i) rd_valid_o <= 1'b0;
         case (mst_q)
            dtm_pkg::DTM_M_IDLE: begin
               if (tq_cnt != 5'h00) begin
                  ref_q <= rev_diff(tq_t[tq_rp_q[3:0]], lat_q);
                  mst_q <= dtm_pkg::DTM_M_HEAD;
               end
            end
            dtm_pkg::DTM_M_HEAD: begin
               if (go) begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= {`DTM_W_HEAD, 12'(tq_e[tq_rp_q[3:0]]), tq_t[tq_rp_q[3:0]], 6'h00};
                  idx_q      <= '0;
                  mask_q     <= '0;
                  mst_q      <= dtm_pkg::DTM_M_SCAN;
               end
            end
            dtm_pkg::DTM_M_SCAN: begin
               if (go) begin
                  if (is_match) begin
                     rd_valid_o <= 1'b1;
                     rd_data_o  <= {1'b1, ent};
                  end
                  if (is_mask) mask_q[ent_ch] <= 1'b1;
                  idx_q <= idx_q + AW'(1);
                  if (idx_q == AW'(DEPTH - 1)) mst_q <= dtm_pkg::DTM_M_MASK;
               end
            end
            dtm_pkg::DTM_M_MASK: begin
               if (go) begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= {`DTM_W_MASK, 30'(mask_q)};
                  mst_q      <= dtm_pkg::DTM_M_IDLE;
               end
            end
            default: mst_q <= dtm_pkg::DTM_M_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   rev_wrap_a: assert property (coarse_q == `DTM_REV_LAST && !bcr && !grst |=> coarse_q == 12'h000)
      else $error("coarse counter did not wrap");
   bcr_load_a: assert property (bcr |=> coarse_q == `DTM_CMD_DLY && ($past(vld_q) & ~vld_q) == '0)
      else $error("bunch reset misloaded counter");
   cnt_step_a: assert property (!bcr && !grst && coarse_q < `DTM_REV_LAST |=> coarse_q == $past(coarse_q) + 12'h001)
      else $error("coarse counter skipped");
   evid_hold_a: assert property (bcr |=> evid_q == $past(evid_q))
      else $error("event number changed on bunch reset");
   evid_clr_a: assert property (ecr |=> evid_q == '0)
      else $error("event number not cleared");
   evid_inc_a: assert property (trig |=> evid_q == $past(evid_q) + 1'b1)
      else $error("event number not advanced");
   hit_store_a: assert property (wr_en && !grst |=> vld_q[$past(wr_ptr_q)])
      else $error("hit not stored");
   chg_sat_a: assert property (wr_en && !ctrl_q[1] |-> wid_q[win] <= 9'(`DTM_CHG_MAX) || $past(ctrl_q[1]))
      else $error("charge width over limit");
   trl_sat_a: assert property (wr_en && ctrl_q[1] && $past(ctrl_q[1]) |-> wid_q[win] <= 9'(`DTM_TRL_MAX))
      else $error("trailing width over limit");
   match_out_a: assert property (mst_q == dtm_pkg::DTM_M_SCAN && go && is_match && !grst
                                 |=> rd_valid_o && rd_data_o[31])
      else $error("matched hit not emitted");
   mask_word_a: assert property (tq_pop && !grst |=> rd_valid_o && rd_data_o[31:30] == `DTM_W_MASK)
      else $error("mask word missing");

   trig_seen_c: cover property (trig ##[1:300] tq_pop);
   mask_seen_c: cover property (mst_q == dtm_pkg::DTM_M_SCAN && is_mask);
   burst_c: cover property ($countones(pend_q) > 2);
   bcr_c: cover property (bcr);

endmodule

// ---- dtm_ttc_src.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Control source model: sends one start bit and two code bits a command.
// ----------------------------------------------------------------------
module dtm_ttc_src #(
   parameter int GAP = 8
) (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Command request from the bench.
   input  wire logic       go_i,
   input  wire logic [1:0] code_i,
   // Encoded line and busy flag.
   output logic            cmd_o,
   output logic            busy_o
);
   logic [3:0] cnt_q;   // Position within the command slot.
   logic [1:0] code_q;  // Code held for the whole command.

   // The slot lasts GAP cycles, so commands keep eight cycles apart and
   // triggers keep 80 ns apart; the line idles low between commands.
   // Triggers come only on request, far below the rate and burst limits.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 4'h0;
         cmd_o <= 1'b0;
      end else if (cnt_q == 4'h0) begin
         cmd_o  <= go_i;
         code_q <= code_i;
         cnt_q  <= go_i ? 4'h1 : 4'h0;
      end else begin
         cmd_o <= (cnt_q == 4'h1) ? code_q[1] : (cnt_q == 4'h2) ? code_q[0] : 1'b0;
         cnt_q <= (cnt_q == 4'(GAP - 1)) ? 4'h0 : cnt_q + 4'h1;
      end
   end

   assign busy_o = (cnt_q != 4'h0);
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "dtm_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb_top;
   // ----------------------------------------------------------------
   // Signals.
   // ----------------------------------------------------------------
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rd_valid, rd_ready = 0, go = 0, cmd, busy;
   logic [7:0]   adr = 8'h00;
   logic [3:0]   sel = 4'h0;
   logic [31:0]  wdat = 32'h0000_0000, rdat, rd_data, r;
   logic [23:0]  hit = 24'h00_0000;
   logic [119:0] fine = '0;
   logic [1:0]   code = 2'h0;
   logic [31:0]  q[$];  // Accepted readout words.
   int seed = 81969, n_errors = 0, total_checks = 0, m, c, ca, cb, fl, ft, k, w, trig;
   logic [11:0]  ev[2];
   logic [7:0]   ra[6] = '{`DTM_A_CTRL, `DTM_A_LAT, `DTM_A_MWIN, `DTM_A_KWIN, `DTM_A_STAT, 8'h18};
   logic [31:0]  rv[6] = '{32'h0000_0001, 32'h0000_00FA, 32'h0000_0050, 32'h0000_0050, 32'h0000_0000, 32'h0000_0000};

   dtm_core u_dtm_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .hit_i(hit),
      .hit_fine_i(fine), .ttc_cmd_i(cmd), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready));
   dtm_ttc_src u_dtm_ttc_src (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .code_i(code), .cmd_o(cmd), .busy_o(busy));

   // Clock, random sink stalls and the readout monitor.
   initial forever #5 clk_i = ~clk_i;
   always @(posedge clk_i) rd_ready <= $random(seed) & 1;
   always @(posedge clk_i) if (rd_valid === 1'b1 && rd_ready === 1'b1) q.push_back(rd_data);

   // One Wishbone classic cycle; only the watchdog ends the wait for acknowledge.
   task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
      @(posedge clk_i);
      cyc  <= 1;
      stb  <= 1;
      we   <= w_en;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      o = rdat;
      cyc <= 0;
      stb <= 0;
      we  <= 0;
   endtask

   // Sends one encoded command and waits until the source is idle again.
   task automatic send(input logic [1:0] cd);
      @(posedge clk_i);
      go   <= 1;
      code <= cd;
      @(posedge clk_i);
      go <= 0;
      do @(posedge clk_i); while (busy !== 1'b0);
   endtask

   // Expected pulse width in output bins for a pulse kc cycles long.
   function automatic int exp_width(input int kc, input int f0, input int f1, input int trl);
      int v;
      v = kc * 32 + f1 - f0;
      return trl ? ((v / 20 > 240) ? 240 : v / 20) : ((v > 480) ? 480 : v);
   endfunction

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Watchdog against a hung handshake.
   initial begin
      #400000;
      n_errors++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      for (int i = 0; i < 6; i++) begin
         wb(0, ra[i], 32'h0, r);
         `CHK(r, rv[i])
      end
      send(`DTM_CMD_BCR);
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[11:0] < 12'h0010, 1'b1)
      send(`DTM_CMD_ECR);
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[27:16], 12'h000)
      // Charge mode, then trailing mode: one masking hit and one matched hit.
      for (m = 0; m < 2; m++) begin
         wb(1, `DTM_A_CTRL, {30'h0, m[0], 1'b1}, r);
         ca = $unsigned($random(seed)) % 24;
         cb = (ca + 1 + $unsigned($random(seed)) % 23) % 24;
         fl = $random(seed) & 31;
         ft = $random(seed) & 31;
         k = 2 + $unsigned($random(seed)) % 9;
         q.delete();
         // Trigger start bit lands 240 cycles after the matched hit.
         for (c = 0; c < 260; c++) begin
            @(posedge clk_i);
            if (c == 0) hit[cb] <= 1;
            if (c == 3) hit[cb] <= 0;
            if (c == 20) begin
               hit[ca]       <= 1;
               fine[ca*5+:5] <= 5'(fl);
            end
            if (c == 20 + k) begin
               hit[ca]       <= 0;
               fine[ca*5+:5] <= 5'(ft);
            end
            go <= (c == 259);
            code <= `DTM_CMD_TRIG;
         end
         @(posedge clk_i);
         go <= 0;
         c = 0;
         while (q.size() < 3 && c < 3000) begin
            @(posedge clk_i);
            c++;
         end
         `CHK(q.size(), 3)
         w = exp_width(k, fl, ft, m);
         ev[m] = q[0][29:18];
         trig = q[0][17:6];
         `CHK(q[0][31:30], 2'h0)
         `CHK(q[1][31], 1'b1)
         `CHK(q[1][30:26], 5'(ca))
         `CHK(q[1][25:14], 12'((trig + 3564 - 240) % 3564))
         `CHK(q[1][13:9], 5'(fl))
         `CHK(q[1][8:0], 9'(w))
         `CHK(q[2][31:30], 2'h1)
         `CHK(q[2][23:0], 24'h00_0001 << cb)
      end
      `CHK(ev[1], ev[0] + 12'h001)
      send(`DTM_CMD_BCR);
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[27:16], 12'h002)
      send(`DTM_CMD_GRST);
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[27:16], 12'h000)
      `CHK(r[11:0] < 12'h0010, 1'b1)
      // One full revolution later the coarse time reads the same again.
      k = r[11:0];
      repeat (3561) @(posedge clk_i);
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[11:0], 12'(k))
      // Burst on every channel, then a second pulse on the last one before it drains.
      hit <= '1;
      @(posedge clk_i);
      hit <= '0;
      @(posedge clk_i);
      hit[23] <= 1;
      @(posedge clk_i);
      hit[23] <= 0;
      repeat (30) @(posedge clk_i);
      wb(0, `DTM_A_STAT, 32'h0, r);
      `CHK(r[0], 1'b1)
      wb(1, `DTM_A_STAT, 32'h1, r);
      wb(0, `DTM_A_STAT, 32'h0, r);
      `CHK(r[1:0], 2'h0)
      // A trigger while disabled is dropped but still numbered.
      wb(1, `DTM_A_CTRL, 32'h0, r);
      send(`DTM_CMD_TRIG);
      wb(0, `DTM_A_STAT, 32'h0, r);
      `CHK(r[1], 1'b1)
      wb(0, `DTM_A_TIME, 32'h0, r);
      `CHK(r[27:16], 12'h001)
      print_verdict();
   end
endmodule
